/* verilog/pwm_pkg.sv */
// shared constants, register map and carrier types of the four-channel pwm
package pwm_pkg;
   localparam int NUM_CH = 4;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_CLK = 10'h040;
   localparam logic [9:0] IDX_POL = 10'h041;
   localparam logic [9:0] IDX_EN = 10'h042;
   localparam logic [9:0] IDX_PRES = 10'h043;
   localparam logic [9:0] IDX_SCAL0 = 10'h044;
   localparam logic [9:0] IDX_SCNT0 = 10'h045;
   localparam logic [9:0] IDX_SCAL1 = 10'h046;
   localparam logic [9:0] IDX_SCNT1 = 10'h047;
   localparam logic [9:0] IDX_CNT0 = 10'h048;
   localparam logic [9:0] IDX_PER0 = 10'h04C;
   localparam logic [9:0] IDX_DUTY0 = 10'h050;
   localparam logic [9:0] IDX_ALIGN = 10'h054;
   // pwm_clock_prescale_and_join fields
   localparam int CLK_JOIN23_BIT = 7;
   localparam int CLK_JOIN01_BIT = 6;
   localparam int CLK_PSA_LSB = 3;
   localparam int CLK_PSB_LSB = 0;
   // pwm_source_select_and_polarity fields
   localparam int POL_SRC_LSB = 4;
   localparam int POL_LVL_LSB = 0;
   // reset values
   localparam logic [7:0] CLK_RST = 8'h00;
   localparam logic [7:0] POL_RST = 8'h00;
   localparam logic [3:0] EN_RST = 4'h0;
   localparam logic [3:0] ALIGN_RST = 4'h0;
   localparam logic [7:0] SCAL_RST = 8'h00;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [7:0] PER_RST = 8'hFF;
   localparam logic [7:0] DUTY_RST = 8'hFF;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic a;
      logic b;
      logic s0;
      logic s1;
   } clk_ticks_t;

   typedef struct packed {
      logic [6:0] pres;
      logic [7:0] scnt0;
      logic [7:0] scnt1;
      logic half0;
      logic half1;
      clk_ticks_t ticks;
   } clkgen_state_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic down;
      logic roll;
   } step_t;

   typedef struct packed {
      logic [7:0] clk_cfg;
      logic [7:0] pol;
      logic [3:0] en;
      logic [3:0] align;
      logic [7:0] scal0;
      logic [7:0] scal1;
      logic [3:0][7:0] cnt;
      logic [3:0][7:0] per_buf;
      logic [3:0][7:0] per_act;
      logic [3:0][7:0] duty_buf;
      logic [3:0][7:0] duty_act;
      logic [3:0] down;
      logic [3:0] pin;
      logic [3:0] pin_oe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pwm_state_t;
endpackage : pwm_pkg

/* verilog/pwm_clock_divider.sv */
// prescaler and scaler chain making clock a, b, s0 and s1 enable pulses
`timescale 1ns/1ps
module pwm_clock_divider (
   input logic clk_i,
   input logic rst_i,
   input logic run_i,
   input logic [2:0] psa_i,
   input logic [2:0] psb_i,
   input logic [7:0] scal0_i,
   input logic [7:0] scal1_i,
   input logic load0_i,
   input logic load1_i,
   output pwm_pkg::clk_ticks_t ticks_o,
   output logic [6:0] pres_o,
   output logic [7:0] scnt0_o,
   output logic [7:0] scnt1_o
);
   import pwm_pkg::*;

   clkgen_state_t r_reg;
   clkgen_state_t r_next;
   logic [6:0] mask_a;
   logic [6:0] mask_b;

   function automatic logic [6:0] div_mask(input logic [2:0] sel);
      logic [7:0] m;
      m = (8'h01 << sel) - 8'h01;
      return m[6:0];
   endfunction : div_mask

   always_comb begin
      r_next = r_reg;
      mask_a = div_mask(psa_i);
      mask_b = div_mask(psb_i);
      // prescaler halts while no channel runs
      if (run_i) begin
         r_next.pres = r_reg.pres + 7'h01;
      end
      r_next.ticks.a = run_i && ((r_reg.pres & mask_a) == mask_a);
      r_next.ticks.b = run_i && ((r_reg.pres & mask_b) == mask_b);
      r_next.ticks.s0 = 1'b0;
      r_next.ticks.s1 = 1'b0;
      // scaled clocks: (reload + 1) ticks, then divide by two
      if (load0_i) begin
         r_next.scnt0 = scal0_i;
         r_next.half0 = 1'b0;
      end else if (r_reg.ticks.a) begin
         if (r_reg.scnt0 == 8'h00) begin
            r_next.scnt0 = scal0_i;
            r_next.half0 = ~r_reg.half0;
            r_next.ticks.s0 = r_reg.half0;
         end else begin
            r_next.scnt0 = r_reg.scnt0 - 8'h01;
         end
      end
      if (load1_i) begin
         r_next.scnt1 = scal1_i;
         r_next.half1 = 1'b0;
      end else if (r_reg.ticks.b) begin
         if (r_reg.scnt1 == 8'h00) begin
            r_next.scnt1 = scal1_i;
            r_next.half1 = ~r_reg.half1;
            r_next.ticks.s1 = r_reg.half1;
         end else begin
            r_next.scnt1 = r_reg.scnt1 - 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign ticks_o = r_reg.ticks;
   assign pres_o = r_reg.pres;
   assign scnt0_o = r_reg.scnt0;
   assign scnt1_o = r_reg.scnt1;
endmodule : pwm_clock_divider

/* verilog/four_channel_pwm_clocking.sv */
// four-channel pwm with apb registers, clock selection and pin takeover
//
// Summary of operation
// - four 8-bit, two 16-bit, or mixed channels
// - own counter, period, duty; 0 to 100 percent
// - each output left or center aligned
// - enabled channel latches new values at rollover
// - disabled channel writes update buffer and latch
// - counter write resets count, latches buffers
// - counters readable; disabling freezes count, enabling resumes it
// - enabled channel overrides general-purpose pin use
// - join 2/3: pin 2 drives, ch3 clock
// - join 0/1: pin 0 drives, ch1 clock
// - clock a/b equal p over two-power code
// - ch2/ch3 select clock b or s1
// - ch0/ch1 select clock a or s0
// - config registers always read/write; polarity resets zero
// - start level bit; output flips at duty
// - s0/s1 divide by reload plus one, two
`timescale 1ns/1ps
module four_channel_pwm_clocking (
   input logic MCLK_I,
   input logic RST_I,
   input pwm_pkg::apb_req_t APB_REQ_I,
   output pwm_pkg::apb_rsp_t APB_RSP_O,
   input logic [3:0] GPIO_OUT_I,
   input logic [3:0] GPIO_OE_I,
   output logic [3:0] PIN_O,
   output logic [3:0] PIN_OE_O
);
   import pwm_pkg::*;

   pwm_state_t r_reg;
   pwm_state_t r_next;
   clk_ticks_t ticks;
   logic [6:0] pres;
   logic [7:0] scnt0;
   logic [7:0] scnt1;
   logic [3:0] tk;
   logic [3:0] eff_en;
   logic [3:0] level;
   logic [3:0] roll;
   logic [3:0] cnt_wr;
   logic [3:0] per_wr;
   logic [3:0] duty_wr;
   logic [1:0] joined;
   logic [9:0] idx;
   logic [7:0] rdat;
   logic [7:0] wd;
   logic hit;
   logic setup;
   logic access;
   logic wr;
   logic load0;
   logic load1;
   step_t st;

   // one counter step; center mode counts up to period then down to zero
   function automatic step_t step(input logic [15:0] c, input logic [15:0] per,
                                  input logic center, input logic down, input logic go);
      step_t o;
      o.cnt = c;
      o.down = down;
      o.roll = 1'b0;
      if (go) begin
         if (!center) begin
            if (({1'b0, c} + 17'h00001) >= {1'b0, per}) begin
               o.cnt = 16'h0000;
               o.roll = 1'b1;
            end else begin
               o.cnt = c + 16'h0001;
            end
         end else if (!down) begin
            if (c >= per) begin
               o.down = 1'b1;
               o.cnt = (c == 16'h0000) ? 16'h0000 : c - 16'h0001;
            end else begin
               o.cnt = c + 16'h0001;
            end
         end else if (c == 16'h0000) begin
            o.down = 1'b0;
            o.roll = 1'b1;
            o.cnt = (per == 16'h0000) ? 16'h0000 : 16'h0001;
         end else begin
            o.cnt = c - 16'h0001;
         end
      end
      return o;
   endfunction : step

   pwm_clock_divider u_div (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .run_i(|r_reg.en),
      .psa_i(r_reg.clk_cfg[CLK_PSA_LSB +: 3]),
      .psb_i(r_reg.clk_cfg[CLK_PSB_LSB +: 3]),
      .scal0_i(r_reg.scal0),
      .scal1_i(r_reg.scal1),
      .load0_i(load0),
      .load1_i(load1),
      .ticks_o(ticks),
      .pres_o(pres),
      .scnt0_o(scnt0),
      .scnt1_o(scnt1)
   );

   always_comb begin
      r_next = r_reg;
      st = '0;
      joined[0] = r_reg.clk_cfg[CLK_JOIN01_BIT];
      joined[1] = r_reg.clk_cfg[CLK_JOIN23_BIT];
      // per-channel clock source
      tk[0] = r_reg.pol[POL_SRC_LSB + 0] ? ticks.s0 : ticks.a;
      tk[1] = r_reg.pol[POL_SRC_LSB + 1] ? ticks.s0 : ticks.a;
      tk[2] = r_reg.pol[POL_SRC_LSB + 2] ? ticks.s1 : ticks.b;
      tk[3] = r_reg.pol[POL_SRC_LSB + 3] ? ticks.s1 : ticks.b;
      level = 4'h0;
      roll = 4'h0;
      eff_en = 4'h0;
      // apb decode
      setup = APB_REQ_I.psel && !APB_REQ_I.penable;
      access = APB_REQ_I.psel && APB_REQ_I.penable && r_reg.pready;
      idx = APB_REQ_I.paddr[11:2];
      hit = (APB_REQ_I.paddr[1:0] == 2'b00);
      wr = access && APB_REQ_I.pwrite && hit;
      wd = APB_REQ_I.pwdata[7:0];
      rdat = 8'h00;
      cnt_wr = 4'h0;
      per_wr = 4'h0;
      duty_wr = 4'h0;
      load0 = 1'b0;
      load1 = 1'b0;
      case (idx)
         IDX_CLK: rdat = r_reg.clk_cfg;
         IDX_POL: rdat = r_reg.pol;
         IDX_EN: rdat = {4'h0, r_reg.en};
         IDX_PRES: rdat = {1'b0, pres};
         IDX_SCAL0: rdat = r_reg.scal0;
         IDX_SCNT0: rdat = scnt0;
         IDX_SCAL1: rdat = r_reg.scal1;
         IDX_SCNT1: rdat = scnt1;
         IDX_ALIGN: rdat = {4'h0, r_reg.align};
         default: begin
            if (idx[9:2] == IDX_CNT0[9:2]) begin
               rdat = r_reg.cnt[idx[1:0]];
               cnt_wr[idx[1:0]] = wr;
            end else if (idx[9:2] == IDX_PER0[9:2]) begin
               rdat = r_reg.per_buf[idx[1:0]];
               per_wr[idx[1:0]] = wr;
            end else if (idx[9:2] == IDX_DUTY0[9:2]) begin
               rdat = r_reg.duty_buf[idx[1:0]];
               duty_wr[idx[1:0]] = wr;
            end else begin
               hit = 1'b0;
            end
         end
      endcase
      // counting per pair, joined or separate
      for (int p = 0; p < 2; p++) begin
         if (joined[p]) begin
            eff_en[2*p] = r_reg.en[2*p];
            eff_en[2*p+1] = r_reg.en[2*p];
            st = step({r_reg.cnt[2*p], r_reg.cnt[2*p+1]},
                      {r_reg.per_act[2*p], r_reg.per_act[2*p+1]},
                      r_reg.align[2*p], r_reg.down[2*p],
                      r_reg.en[2*p] && tk[2*p+1]);
            r_next.cnt[2*p] = st.cnt[15:8];
            r_next.cnt[2*p+1] = st.cnt[7:0];
            r_next.down[2*p] = st.down;
            roll[2*p] = st.roll;
            roll[2*p+1] = st.roll;
            level[2*p] = ({r_reg.cnt[2*p], r_reg.cnt[2*p+1]} <
                          {r_reg.duty_act[2*p], r_reg.duty_act[2*p+1]}) ?
                         r_reg.pol[POL_LVL_LSB + 2*p] : ~r_reg.pol[POL_LVL_LSB + 2*p];
         end else begin
            for (int q = 0; q < 2; q++) begin
               eff_en[2*p+q] = r_reg.en[2*p+q];
               st = step({8'h00, r_reg.cnt[2*p+q]}, {8'h00, r_reg.per_act[2*p+q]},
                         r_reg.align[2*p+q], r_reg.down[2*p+q],
                         r_reg.en[2*p+q] && tk[2*p+q]);
               r_next.cnt[2*p+q] = st.cnt[7:0];
               r_next.down[2*p+q] = st.down;
               roll[2*p+q] = st.roll;
               level[2*p+q] = (r_reg.cnt[2*p+q] < r_reg.duty_act[2*p+q]) ?
                              r_reg.pol[POL_LVL_LSB + 2*p+q] :
                              ~r_reg.pol[POL_LVL_LSB + 2*p+q];
            end
         end
      end
      // latch buffers at rollover or while disabled
      for (int k = 0; k < NUM_CH; k++) begin
         if (roll[k] || !eff_en[k]) begin
            r_next.per_act[k] = r_reg.per_buf[k];
            r_next.duty_act[k] = r_reg.duty_buf[k];
         end
         if (per_wr[k]) begin
            r_next.per_buf[k] = wd;
            if (!eff_en[k]) begin
               r_next.per_act[k] = wd;
            end
         end
         if (duty_wr[k]) begin
            r_next.duty_buf[k] = wd;
            if (!eff_en[k]) begin
               r_next.duty_act[k] = wd;
            end
         end
      end
      // counter write resets the counter, both bytes when joined
      for (int k = 0; k < NUM_CH; k++) begin
         if (cnt_wr[k] || (joined[k/2] && cnt_wr[k^1])) begin
            r_next.cnt[k] = CNT_RST;
            r_next.down[k] = 1'b0;
            r_next.per_act[k] = per_wr[k] ? wd : r_reg.per_buf[k];
            r_next.duty_act[k] = duty_wr[k] ? wd : r_reg.duty_buf[k];
         end
      end
      if (wr) begin
         case (idx)
            IDX_CLK: r_next.clk_cfg = wd;
            IDX_POL: r_next.pol = wd;
            IDX_EN: r_next.en = wd[3:0];
            IDX_ALIGN: r_next.align = wd[3:0];
            IDX_SCAL0: begin
               r_next.scal0 = wd;
               load0 = 1'b1;
            end
            IDX_SCAL1: begin
               r_next.scal1 = wd;
               load1 = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // pin takeover; low byte pin of a joined pair goes back to the port
      for (int k = 0; k < NUM_CH; k++) begin
         if (r_reg.en[k] && !(joined[k/2] && (k % 2 == 1))) begin
            r_next.pin[k] = level[k];
            r_next.pin_oe[k] = 1'b1;
         end else begin
            r_next.pin[k] = GPIO_OUT_I[k];
            r_next.pin_oe[k] = GPIO_OE_I[k];
         end
      end
      r_next.pready = setup;
      r_next.pslverr = setup && !hit;
      if (setup) begin
         r_next.prdata = {24'h000000, rdat};
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         r_reg <= '0;
         r_reg.clk_cfg <= CLK_RST;
         r_reg.pol <= POL_RST;
         r_reg.en <= EN_RST;
         r_reg.align <= ALIGN_RST;
         r_reg.scal0 <= SCAL_RST;
         r_reg.scal1 <= SCAL_RST;
         r_reg.per_buf <= {NUM_CH{PER_RST}};
         r_reg.per_act <= {NUM_CH{PER_RST}};
         r_reg.duty_buf <= {NUM_CH{DUTY_RST}};
         r_reg.duty_act <= {NUM_CH{DUTY_RST}};
      end else begin
         r_reg <= r_next;
      end
   end

   assign APB_RSP_O = '{prdata: r_reg.prdata, pready: r_reg.pready, pslverr: r_reg.pslverr};
   assign PIN_O = r_reg.pin;
   assign PIN_OE_O = r_reg.pin_oe;

   property p_pol_reset;
      @(posedge MCLK_I) disable iff (RST_I)
      $fell(RST_I) |-> (r_reg.pol == 8'h00) && (r_reg.clk_cfg == 8'h00);
   endproperty
   a_pol_reset: assert property (p_pol_reset) else $error("config not zero after reset");

   property p_cnt_write;
      @(posedge MCLK_I) disable iff (RST_I)
      cnt_wr[0] |=> (r_reg.cnt[0] == 8'h00) && (r_reg.per_act[0] == r_reg.per_buf[0]);
   endproperty
   a_cnt_write: assert property (p_cnt_write) else $error("counter write did not reset");

   property p_dis_write;
      @(posedge MCLK_I) disable iff (RST_I)
      (per_wr[1] && !eff_en[1]) |=> (r_reg.per_act[1] == $past(wd));
   endproperty
   a_dis_write: assert property (p_dis_write) else $error("disabled write missed latch");

   property p_hold_active;
      @(posedge MCLK_I) disable iff (RST_I)
      (eff_en[2] && !roll[2] && !cnt_wr[2] && !cnt_wr[3]) |=> $stable(r_reg.per_act[2]);
   endproperty
   a_hold_active: assert property (p_hold_active) else $error("active period changed early");

   property p_pin_take;
      @(posedge MCLK_I) disable iff (RST_I)
      r_reg.en[0] |=> PIN_OE_O[0];
   endproperty
   a_pin_take: assert property (p_pin_take) else $error("enabled pin not driven");

   property p_join23_pin;
      @(posedge MCLK_I) disable iff (RST_I)
      joined[1] |=> (PIN_OE_O[3] == $past(GPIO_OE_I[3])) && (PIN_O[3] == $past(GPIO_OUT_I[3]));
   endproperty
   a_join23_pin: assert property (p_join23_pin) else $error("ch3 pin not released");

   property p_join01_pin;
      @(posedge MCLK_I) disable iff (RST_I)
      joined[0] |=> (PIN_OE_O[1] == $past(GPIO_OE_I[1])) && (PIN_O[1] == $past(GPIO_OUT_I[1]));
   endproperty
   a_join01_pin: assert property (p_join01_pin) else $error("ch1 pin not released");

   property p_clka_div2;
      @(posedge MCLK_I) disable iff (RST_I)
      (r_reg.clk_cfg[CLK_PSA_LSB +: 3] == 3'h1) ##1
      (ticks.a && r_reg.clk_cfg[CLK_PSA_LSB +: 3] == 3'h1 && |r_reg.en) ##1
      (r_reg.clk_cfg[CLK_PSA_LSB +: 3] == 3'h1 && |r_reg.en) [*2]
      |-> !$past(ticks.a) && ticks.a;
   endproperty
   a_clka_div2: assert property (p_clka_div2) else $error("clock a not p over two");

   property p_zero_duty;
      @(posedge MCLK_I) disable iff (RST_I)
      (r_reg.en[2] && !joined[1] && r_reg.duty_act[2] == 8'h00) [*2]
      |-> PIN_O[2] == ~$past(r_reg.pol[POL_LVL_LSB + 2]);
   endproperty
   a_zero_duty: assert property (p_zero_duty) else $error("zero duty not at idle level");
endmodule : four_channel_pwm_clocking

/* bench/pin_load_model.sv */
// port pin load model: resolves pad level and flags rising edges
`timescale 1ns/1ps
module pin_load_model (
   input logic clk_i,
   input logic [3:0] pin_i,
   input logic [3:0] pin_oe_i,
   input logic [3:0] gpio_out_i,
   input logic [3:0] gpio_oe_i,
   output logic [3:0] level_o,
   output logic [3:0] rise_o
);
   logic [3:0] prev_reg;
   // pads nobody drives are pulled up
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         level_o[i] = pin_oe_i[i] ? pin_i[i] : (gpio_oe_i[i] ? gpio_out_i[i] : 1'b1);
      end
   end
   always_ff @(posedge clk_i) begin
      prev_reg <= level_o;
   end
   assign rise_o = level_o & ~prev_reg;
endmodule : pin_load_model

/* bench/tb.sv */
// self-checking bench for the four-channel pwm
`timescale 1ns/1ps
module tb;
   import pwm_pkg::*;
   logic mclk;
   logic rst;
   apb_req_t req;
   apb_rsp_t rsp;
   logic [3:0] gpio_out;
   logic [3:0] gpio_oe;
   logic [3:0] pin;
   logic [3:0] pin_oe;
   logic [3:0] lvl;
   logic [3:0] rise;
   int error_cnt = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] rdat;
   logic [31:0] c0;
   logic err;

   four_channel_pwm_clocking uut (.MCLK_I(mclk), .RST_I(rst), .APB_REQ_I(req),
      .APB_RSP_O(rsp), .GPIO_OUT_I(gpio_out), .GPIO_OE_I(gpio_oe), .PIN_O(pin),
      .PIN_OE_O(pin_oe));
   pin_load_model loads (.clk_i(mclk), .pin_i(pin), .pin_oe_i(pin_oe),
      .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .level_o(lvl), .rise_o(rise));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task end_of_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one transfer, then one idle cycle so requests never collide
   task apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00},
         pwdata: {24'h000000, wd}};
      @(posedge mclk);
      req.penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (rsp.pready !== 1'b1);
      rdat = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      @(posedge mclk);
   endtask : apb

   task wr(input logic [9:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task rd(input logic [9:0] idx);
      apb(1'b0, idx, 8'h00);
   endtask : rd

   task setup(input int ch, input logic [7:0] p, input logic [7:0] d);
      wr(IDX_PER0 + 10'(ch), p);
      wr(IDX_DUTY0 + 10'(ch), d);
      wr(IDX_CNT0 + 10'(ch), 8'h00);
   endtask : setup

   task clear;
      wr(IDX_EN, 8'h00);
      wr(IDX_CLK, 8'h00);
      wr(IDX_POL, 8'h00);
      wr(IDX_ALIGN, 8'h00);
   endtask : clear

   task high_cnt(input int p, input int exp, input string nm);
      int h;
      h = 0;
      repeat (16) @(posedge mclk);
      repeat (40) begin
         @(posedge mclk);
         h += int'(lvl[p]);
      end
      chk(nm, exp, h);
   endtask : high_cnt

   // cycles between the second and third rising edge seen
   task period_chk(input int p, input int exp, input string nm);
      int n;
      n = 0;
      for (int i = 0; i < 3; i++) begin
         n = 0;
         do begin
            @(posedge mclk);
            n++;
         end while (rise[p] !== 1'b1 && n < 3000);
      end
      chk(nm, exp, n);
   endtask : period_chk

   task t_reset;
      chk("pin_passthrough", 32'hF5, {pin_oe, pin});
      rd(IDX_CLK);
      chk("clk_reg_reset", 32'h0, rdat);
      rd(IDX_POL);
      chk("pol_reg_reset", 32'h0, rdat);
      apb(1'b0, 10'h060, 8'h00);
      chk("unmapped_err", 32'h1, err);
      wr(IDX_CLK, 8'hC5);
      rd(IDX_CLK);
      chk("clk_reg_rw", 32'hC5, rdat);
      wr(IDX_POL, 8'hA5);
      rd(IDX_POL);
      chk("pol_reg_rw", 32'hA5, rdat);
      clear();
   endtask : t_reset

   task t_wave;
      setup(0, 8'h04, 8'h01);
      wr(IDX_EN, 8'h01);
      high_cnt(0, 30, "pol0_high");
      chk("ch0_takeover", 32'h1, pin_oe[0]);
      wr(IDX_POL, 8'h01);
      high_cnt(0, 10, "pol1_high");
      wr(IDX_DUTY0, 8'h04);
      high_cnt(0, 40, "duty_full");
      wr(IDX_DUTY0, 8'h00);
      high_cnt(0, 0, "duty_zero");
      clear();
   endtask : t_wave

   task t_prescale;
      setup(0, 8'h02, 8'h01);
      setup(2, 8'h02, 8'h01);
      wr(IDX_EN, 8'h05);
      for (int k = 0; k < 8; k++) begin
         wr(IDX_CLK, 8'(k << 3));
         period_chk(0, 2 << k, "clock_a_period");
      end
      wr(IDX_CLK, 8'h02);
      period_chk(2, 8, "clock_b_period");
      wr(IDX_DUTY0 + 10'd2, 8'h00);
      high_cnt(2, 40, "ch2_duty_zero");
      clear();
   endtask : t_prescale

   task t_scaled;
      for (int ch = 0; ch < 4; ch++) begin
         clear();
         wr(IDX_CLK, 8'h08);
         wr(IDX_SCAL0, 8'h02);
         wr(IDX_SCAL1, 8'h01);
         wr(IDX_POL, 8'(1 << (4 + ch)));
         setup(ch, 8'h02, 8'h01);
         wr(IDX_EN, 8'(1 << ch));
         period_chk(ch, (ch < 2) ? 24 : 8, "scaled_period");
      end
      clear();
   endtask : t_scaled

   task t_buffer;
      int n;
      setup(0, 8'd200, 8'd100);
      wr(IDX_EN, 8'h01);
      wr(IDX_PER0, 8'h04);
      wr(IDX_DUTY0, 8'h02);
      rd(IDX_CNT0);
      chk("period_held", 32'h1, {31'h0, rdat > 32'd4});
      wr(IDX_CNT0, 8'h00);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (rise[0] !== 1'b1 && n < 300);
      chk("forced_latch", 32'h1, {31'h0, n <= 8});
      wr(IDX_EN, 8'h00);
      rd(IDX_CNT0);
      c0 = rdat;
      rd(IDX_CNT0);
      chk("count_frozen", c0, rdat);
      clear();
   endtask : t_buffer

   // 16-bit period 260 on the low channel's scaled clock gives 520
   task t_join;
      int hi;
      int lo;
      gpio_oe <= 4'h0;
      for (int j = 0; j < 2; j++) begin
         hi = 2 * j;
         lo = hi + 1;
         clear();
         wr(IDX_CLK, (j == 0) ? 8'h40 : 8'h80);
         wr(IDX_SCAL0, 8'h00);
         wr(IDX_SCAL1, 8'h00);
         wr(IDX_POL, 8'(1 << (4 + lo)));
         setup(hi, 8'h01, 8'h00);
         setup(lo, 8'h04, 8'h82);
         wr(IDX_EN, 8'(3 << hi));
         period_chk(hi, 520, "joined_period");
         chk("low_pin_gpio", 32'h0, pin_oe[lo]);
      end
      clear();
      gpio_oe <= 4'hF;
   endtask : t_join

   task t_center;
      wr(IDX_ALIGN, 8'h01);
      setup(0, 8'h04, 8'h02);
      wr(IDX_EN, 8'h01);
      period_chk(0, 8, "center_period");
      clear();
   endtask : t_center

   initial begin
      rst = 1'b1;
      req = '0;
      gpio_out = 4'h5;
      gpio_oe = 4'hF;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      t_reset();
      t_wave();
      t_prescale();
      t_scaled();
      t_buffer();
      t_join();
      t_center();
      end_of_test();
   end
endmodule : tb
